// file: mmd_pkg.sv
// package: address map constants and carrier types for the memory map decoder
package mmd_pkg;
  localparam int AW = 24;                                // data word address width
  localparam int PW = 21;                                // program word address width
  // program space
  localparam logic [20:0] P_FLASH_LO = 21'h000000;       // boot location
  localparam logic [20:0] P_FLASH_HI = 21'h007FFF;
  localparam logic [20:0] P_RAM_LO   = 21'h008000;
  localparam logic [20:0] P_RAM_HI   = 21'h008FFF;
  localparam logic [20:0] P_VEC_HI   = 21'h000085;       // end of vector table
  // data space
  localparam logic [23:0] X_RAM_LO   = 24'h000000;
  localparam logic [23:0] X_RAM_HI   = 24'h000FFF;
  localparam logic [23:0] X_ALI_LO   = 24'h008000;
  localparam logic [23:0] X_ALI_HI   = 24'h008FFF;
  localparam logic [23:0] X_PER_LO   = 24'h00F000;
  localparam logic [23:0] X_PER_HI   = 24'h00FFFF;
  localparam logic [23:0] X_DBG_LO   = 24'hFFFF00;
  localparam logic [23:0] X_DBG_HI   = 24'hFFFFFF;
  localparam logic [23:0] X_DIR_HI   = 24'h00003F;       // direct mode reach
  localparam logic [11:0] RAM_IDX_MASK = 12'hFFF;        // ram word index
  // vectors
  localparam int VB_W = 14;                              // base width
  localparam int VO_W = 7;                               // offset width
  localparam logic [13:0] VB_RST     = 14'h0000;
  localparam logic [6:0]  VEC_CHIP   = 7'h00;
  localparam logic [6:0]  VEC_WDOG   = 7'h02;            // vector 1 word address
  // peripheral count and bases, ascending
  localparam int NPER = 31;
  localparam logic [15:0] PER_END = 16'hFFFF;            // top of window
  localparam logic [15:0] PER_BASE [NPER] = '{
    16'hF000, 16'hF040, 16'hF080, 16'hF0C0, 16'hF0E0, 16'hF100, 16'hF110,
    16'hF120, 16'hF130, 16'hF140, 16'hF150, 16'hF160, 16'hF170, 16'hF180,
    16'hF190, 16'hF1A0, 16'hF1B0, 16'hF1C0, 16'hF1D0, 16'hF1E0, 16'hF1F0,
    16'hF200, 16'hF210, 16'hF220, 16'hF230, 16'hF240, 16'hF250, 16'hF260,
    16'hF300, 16'hF400, 16'hF440};
  // data targets
  typedef enum logic [2:0] {MMD_T_NONE, MMD_T_RAM, MMD_T_PER, MMD_T_DBG} mmd_tgt_t;
  // transfer sizes
  typedef enum logic [1:0] {MMD_SZ_BYTE, MMD_SZ_WORD, MMD_SZ_LONG} mmd_size_t;
  // primary data request
  typedef struct packed {
    logic              rd;
    logic              wr;
    mmd_size_t         size;
    logic [23:0]       addr;
    logic [31:0]       wdata;
  } mmd_dreq_t;
endpackage : mmd_pkg

// file: mmd_decoder.sv
// module: program and data space address decoder with vector address former
`timescale 1ns/1ps
`default_nettype none
// How it works
// RQ1: program 0..7FFF selects flash, boot at zero
// RQ2: program 8000..8FFF selects the shared RAM
// RQ3: program data moves use core read/write buses
// RQ4: data 0..0FFF selects the data RAM
// RQ5: data 8000..8FFF aliases the data RAM
// RQ6: peripherals F000..FFFF, debug FFFF00..FFFFFF
// RQ7: addresses count sixteen-bit words
// RQ8: primary buses 32 bits, byte word long
// RQ9: secondary 16-bit read runs in parallel
// RQ10: direct mode reaches lowest 64 words
// RQ11: vector = base upper 14, offset lower 7
// RQ12: vector base resets to zero
// RQ13: vector table spans zero to 85
// RQ14: watchdog reset uses vector 1, chip 0
// RQ15: image puts jumps then calls in table
// RQ16: initiators use word access to peripherals
// RQ17: timers, converter, then system blocks ascend
// RQ18: serial interfaces at F1E0, F1F0, F200
// RQ19: check generator selected at F230
// RQ20: references at F240, F250, F260
// RQ21: modulator F300, flash F400, network F440
// RQ22: debug reachable over JTAG when unsecured
// RQ23: reserved regions read zero, ignore writes
// RQ24: each select spans base to next base
module mmd_decoder #(
  parameter int RAM_WORDS = 4096                         // shared ram depth in words
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  // program fetch side
  input  wire logic                    fetch_en,
  input  wire logic [20:0]             program_addr_bus,
  output logic      [15:0]             program_fetch_bus,
  output logic                         fetch_flash_sel,
  output logic      [14:0]             flash_addr,
  input  wire logic [15:0]             flash_rdata,
  // primary data side
  input  wire mmd_pkg::mmd_dreq_t      dreq,
  input  wire logic                    dreq_pspace,
  output logic      [31:0]             core_read_bus,
  output logic                         dack,
  // secondary read
  input  wire logic                    sec_rd,
  input  wire logic [23:0]             secondary_data_addr_bus,
  output logic      [15:0]             secondary_read_bus,
  // direct mode
  input  wire logic                    dir_en,
  input  wire logic [5:0]              dir_field,
  output logic      [23:0]             dir_addr,
  // peripheral window
  output logic      [mmd_pkg::NPER-1:0] per_sel,
  output logic      [23:0]             per_addr,
  output logic                         per_wr,
  output logic      [15:0]             per_wdata,
  input  wire logic [15:0]             per_rdata,
  // debug window
  output logic                         dbg_sel,
  output logic      [7:0]              dbg_offset,
  input  wire logic [15:0]             dbg_rdata,
  input  wire logic                    jtag_dbg_req,
  input  wire logic                    flash_secure,
  output logic                         jtag_dbg_grant,
  // vectors
  input  wire logic                    vb_wr,
  input  wire logic [13:0]             vb_wdata,
  input  wire logic                    irq_pend,
  input  wire logic [6:0]              irq_offset,
  input  wire logic                    wdog_rst,
  output logic      [13:0]             vector_base_reg,
  output logic      [20:0]             vector_address,
  output logic                         vec_in_table
);
  // elaboration guard: the index logic assumes a 4096 word ram
  if (RAM_WORDS != 4096) begin : g_depth_check
    $error("ram depth must be 4096 words");
  end

  // ****************************************
  // reset release and input synchronisers
  // ****************************************
  logic [1:0] rst_sync_reg;                              // reset release pair
  logic       rst_n;                                     // released reset
  logic [1:0] sec_s_reg;                                 // secure pin sync
  logic [1:0] jtag_s_reg;                                // jtag request sync
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) rst_sync_reg <= 2'h0;
    else       rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // two flops before the pin levels are read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sec_s_reg  <= 2'h3;                                // secure until seen
      jtag_s_reg <= 2'h0;
    end else begin
      sec_s_reg  <= {sec_s_reg[0], flash_secure};
      jtag_s_reg <= {jtag_s_reg[0], jtag_dbg_req};
    end
  end

  // ****************************************
  // decode functions
  // ****************************************
  // data-space word address to target
  function automatic mmd_pkg::mmd_tgt_t dmap(input logic [23:0] a);
    if (a <= mmd_pkg::X_RAM_HI) dmap = mmd_pkg::MMD_T_RAM;                      // [RQ4] [RQ7]
    else if (a >= mmd_pkg::X_ALI_LO && a <= mmd_pkg::X_ALI_HI) dmap = mmd_pkg::MMD_T_RAM; // [RQ5]
    else if (a >= mmd_pkg::X_PER_LO && a <= mmd_pkg::X_PER_HI) dmap = mmd_pkg::MMD_T_PER; // [RQ6]
    else if (a >= mmd_pkg::X_DBG_LO) dmap = mmd_pkg::MMD_T_DBG;                 // [RQ6]
    else dmap = mmd_pkg::MMD_T_NONE;                                            // [RQ23]
  endfunction : dmap

  // program-space word address to target
  function automatic mmd_pkg::mmd_tgt_t pmap(input logic [20:0] a);
    if (a <= mmd_pkg::P_FLASH_HI) pmap = mmd_pkg::MMD_T_PER;                    // flash code [RQ1]
    else if (a >= mmd_pkg::P_RAM_LO && a <= mmd_pkg::P_RAM_HI) pmap = mmd_pkg::MMD_T_RAM; // [RQ2]
    else pmap = mmd_pkg::MMD_T_NONE;                                            // [RQ23]
  endfunction : pmap

  // ****************************************
  // shared ram
  // ****************************************
  logic [15:0] ram_mem [RAM_WORDS];                      // unified 8 KB
  mmd_pkg::mmd_tgt_t d_tgt;                              // primary target
  mmd_pkg::mmd_tgt_t p_tgt;                              // fetch target
  mmd_pkg::mmd_tgt_t pd_tgt;                             // program data move target
  mmd_pkg::mmd_tgt_t s_tgt;                              // secondary target
  logic [11:0] d_idx;                                    // primary ram index
  logic        d_ram;                                    // primary hits ram
  logic        d_wr_ram;                                 // ram write strobe
  logic        d_hi;                                     // long upper word in ram

  assign d_tgt  = dmap(dreq.addr);
  assign p_tgt  = pmap(program_addr_bus);
  assign pd_tgt = pmap(dreq.addr[20:0]);
  assign s_tgt  = dmap(secondary_data_addr_bus);
  // alias and program window fold onto the same index
  assign d_idx  = dreq.addr[11:0] & mmd_pkg::RAM_IDX_MASK;                      // [RQ2] [RQ5]
  assign d_ram  = dreq_pspace ? (pd_tgt == mmd_pkg::MMD_T_RAM) : (d_tgt == mmd_pkg::MMD_T_RAM);
  assign d_wr_ram = dreq.wr && d_ram;
  assign d_hi   = (d_idx != mmd_pkg::RAM_IDX_MASK);      // long must not wrap

  // ram writes: byte into low lanes, long splits into two words
  always_ff @(posedge clk_sys) begin
    if (d_wr_ram) begin                                                         // [RQ8]
      case (dreq.size)
        mmd_pkg::MMD_SZ_BYTE: ram_mem[d_idx][7:0] <= dreq.wdata[7:0];
        mmd_pkg::MMD_SZ_LONG: begin
          ram_mem[d_idx] <= dreq.wdata[15:0];
          if (d_hi) ram_mem[d_idx + 12'h001] <= dreq.wdata[31:16];
        end
        default: ram_mem[d_idx] <= dreq.wdata[15:0];
      endcase
    end
  end

  // ****************************************
  // primary read path and stall
  // ****************************************
  logic        pwait_reg;                                // program move extra cycle
  logic [31:0] rd_next;                                  // read value
  always_comb begin
    rd_next = 32'h0000_0000;                             // reserved reads zero [RQ23]
    if (d_ram) begin
      rd_next[15:0] = ram_mem[d_idx];
      if (dreq.size == mmd_pkg::MMD_SZ_LONG && d_hi) rd_next[31:16] = ram_mem[d_idx + 12'h001];
      if (dreq.size == mmd_pkg::MMD_SZ_BYTE) rd_next[15:8] = 8'h00;
    end else if (dreq_pspace && pd_tgt == mmd_pkg::MMD_T_PER) begin
      rd_next[15:0] = flash_rdata;                       // program data read [RQ3]
    end else if (!dreq_pspace && d_tgt == mmd_pkg::MMD_T_PER) begin
      rd_next[15:0] = per_rdata;
    end else if (!dreq_pspace && d_tgt == mmd_pkg::MMD_T_DBG) begin
      rd_next[15:0] = dbg_rdata;
    end
  end

  // program-space moves hold the core one extra cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) pwait_reg <= 1'b0;
    else        pwait_reg <= (dreq.rd || dreq.wr) && dreq_pspace && !pwait_reg; // [RQ3]
  end

  // registered read data and ack
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_read_bus <= 32'h0000_0000;
      dack          <= 1'b0;
    end else begin
      core_read_bus <= rd_next;                                                 // [RQ8]
      dack          <= (dreq.rd || dreq.wr) && (!dreq_pspace || pwait_reg);     // [RQ3] [RQ23]
    end
  end

  // ****************************************
  // fetch and secondary read
  // ****************************************
  assign fetch_flash_sel = fetch_en && p_tgt == mmd_pkg::MMD_T_PER;             // [RQ1]
  assign flash_addr = dreq_pspace && !fetch_en ? dreq.addr[14:0] : program_addr_bus[14:0];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      program_fetch_bus  <= 16'h0000;
      secondary_read_bus <= 16'h0000;
    end else begin
      if (p_tgt == mmd_pkg::MMD_T_RAM) program_fetch_bus <= ram_mem[program_addr_bus[11:0]]; // [RQ2]
      else if (p_tgt == mmd_pkg::MMD_T_PER) program_fetch_bus <= flash_rdata;   // [RQ1]
      else program_fetch_bus <= 16'h0000;
      // parallel secondary read, ram only
      if (sec_rd && s_tgt == mmd_pkg::MMD_T_RAM)
        secondary_read_bus <= ram_mem[secondary_data_addr_bus[11:0]];           // [RQ9]
      else
        secondary_read_bus <= 16'h0000;
    end
  end

  // direct mode maps the short field onto the lowest words
  assign dir_addr = dir_en ? {18'h00000, dir_field} : 24'h000000;              // [RQ10]

  // ****************************************
  // peripheral and debug selects
  // ****************************************
  logic acc;                                             // primary data access
  assign acc        = (dreq.rd || dreq.wr) && !dreq_pspace;
  assign per_addr   = dreq.addr;
  assign per_wr     = acc && dreq.wr && d_tgt == mmd_pkg::MMD_T_PER;            // no strobe on program moves [RQ23]
  assign per_wdata  = dreq.wdata[15:0];                  // word lanes only
  assign dbg_offset = dreq.addr[7:0];
  assign dbg_sel    = acc && d_tgt == mmd_pkg::MMD_T_DBG;                       // [RQ6]
  assign jtag_dbg_grant = jtag_s_reg[1] && !sec_s_reg[1];                       // [RQ22]

  // one select per base, each up to the next base
  genvar gi;
  generate
    for (gi = 0; gi < mmd_pkg::NPER; gi++) begin : g_per
      // next index clamped so the last select never reads past the table
      localparam int          NX = (gi == mmd_pkg::NPER - 1) ? gi : gi + 1;
      localparam logic [15:0] HI = (gi == mmd_pkg::NPER - 1) ? mmd_pkg::PER_END
                                 : 16'(mmd_pkg::PER_BASE[NX] - 16'h0001);
      assign per_sel[gi] = acc && d_tgt == mmd_pkg::MMD_T_PER  // [RQ17] [RQ18] [RQ19] [RQ20] [RQ21] [RQ24]
                         && dreq.addr[15:0] >= mmd_pkg::PER_BASE[gi] && dreq.addr[15:0] <= HI;
    end
  endgenerate

  // ****************************************
  // vector base and vector address
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)     vector_base_reg <= mmd_pkg::VB_RST;                        // [RQ12]
    else if (vb_wr) vector_base_reg <= vb_wdata;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) vector_address <= 21'h000000;                                   // [RQ12]
    else if (wdog_rst) vector_address <= {vector_base_reg, mmd_pkg::VEC_WDOG};  // [RQ14]
    else if (irq_pend) vector_address <= {vector_base_reg, irq_offset};         // [RQ11]
    else vector_address <= {vector_base_reg, mmd_pkg::VEC_CHIP};                // [RQ14]
  end
  assign vec_in_table = vector_address <= mmd_pkg::P_VEC_HI;                   // [RQ13]

  // ****************************************
  // assertions
  // ****************************************
  property p_vec_form;
    @(posedge clk_sys) disable iff (!rst_n) irq_pend && !wdog_rst |=>
      vector_address == {$past(vector_base_reg), $past(irq_offset)};
  endproperty
  a_vec_form: assert property (p_vec_form) else $error("vector address misformed"); // [RQ11]
  property p_wdog;
    @(posedge clk_sys) disable iff (!rst_n) wdog_rst |=> vector_address[6:0] == 7'h02;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog vector wrong"); // [RQ14]
  property p_dbg;
    @(posedge clk_sys) disable iff (!rst_n) dbg_sel |-> dreq.addr >= 24'hFFFF00;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug select outside window"); // [RQ6]
  property p_onehot;
    @(posedge clk_sys) disable iff (!rst_n) $onehot0(per_sel);
  endproperty
  a_onehot: assert property (p_onehot) else $error("overlapping peripheral selects"); // [RQ24]
  property p_per_range;
    @(posedge clk_sys) disable iff (!rst_n) |per_sel |-> dreq.addr[23:12] == 12'h00F;
  endproperty
  a_per_range: assert property (p_per_range) else $error("peripheral select outside window"); // [RQ6]
  property p_ts0;
    @(posedge clk_sys) disable iff (!rst_n) acc && dreq.addr == 24'h00F23F |-> per_sel[24];
  endproperty
  a_ts0: assert property (p_ts0) else $error("check generator range wrong"); // [RQ19]
  property p_resv;
    @(posedge clk_sys) disable iff (!rst_n) dreq.rd && !dreq_pspace && dreq.addr[23:12] == 12'h001 |=>
      core_read_bus == 32'h0 && dack;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved read not zero"); // [RQ23]
  property p_pslow;
    @(posedge clk_sys) disable iff (!rst_n) dreq.rd && dreq_pspace && !pwait_reg |=> !dack ##1 dack;
  endproperty
  a_pslow: assert property (p_pslow) else $error("program move not delayed"); // [RQ3]
  property p_jtag;
    @(posedge clk_sys) disable iff (!rst_n) jtag_dbg_grant |->
      !$past(flash_secure, 2) && $past(jtag_dbg_req, 2);
  endproperty
  a_jtag: assert property (p_jtag) else $error("jtag granted while secure"); // [RQ22]
  c_per: cover property (@(posedge clk_sys) disable iff (!rst_n) |per_sel);
  c_dbg: cover property (@(posedge clk_sys) disable iff (!rst_n) dbg_sel);
  c_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) irq_pend ##1 vec_in_table);
endmodule : mmd_decoder
`default_nettype wire

// file: mmd_far_model.sv
// partner model: program flash image and peripheral and debug responders
`timescale 1ns/1ps
`default_nettype none
module mmd_far_model (
  input  wire logic                     clk_sys,
  input  wire logic [14:0]              flash_addr,
  output logic      [15:0]              flash_rdata,
  input  wire logic [mmd_pkg::NPER-1:0] per_sel,
  input  wire logic [23:0]              per_addr,
  output logic      [15:0]              per_rdata,
  input  wire logic                     dbg_sel,
  input  wire logic [7:0]               dbg_offset,
  output logic      [15:0]              dbg_rdata
);
  logic [15:0] junk_reg = 16'hA5A5;  // churning pattern for released lines
  // pattern moves every cycle so a stale value never looks valid
  always @(posedge clk_sys) begin
    junk_reg <= junk_reg + 16'h3C3D;
  end
  // flash image word derived from its address, jumps and calls alike
  assign flash_rdata = {1'b1, flash_addr ^ 15'h1234};
  // peripheral answers only while selected
  assign per_rdata = (|per_sel) ? (per_addr[15:0] ^ 16'h0F0F) : junk_reg;
  // debug window answers only while selected
  assign dbg_rdata = dbg_sel ? {8'hDB, dbg_offset} : ~junk_reg;
endmodule : mmd_far_model
`default_nettype wire

// file: tb_memory_map_address_decoder.sv
// testbench: scenarios for the memory map decoder against a far side model
`timescale 1ns/1ps
`default_nettype none
module tb_memory_map_address_decoder;
  logic clk_sys = 1'b0, rstn, fetch_en, dreq_pspace, dack, sec_rd, dir_en, per_wr;
  logic dbg_sel, jtag_dbg_req, flash_secure, jtag_dbg_grant, vb_wr, irq_pend;
  logic wdog_rst, vec_in_table, fetch_flash_sel, dsel_seen;
  logic [16:0] wr_seen;
  logic [20:0] program_addr_bus, vector_address;
  logic [15:0] program_fetch_bus, flash_rdata, secondary_read_bus, per_wdata, per_rdata, dbg_rdata;
  logic [14:0] flash_addr;
  logic [31:0] core_read_bus, rd_val;
  logic [23:0] secondary_data_addr_bus, dir_addr, per_addr;
  logic [5:0]  dir_field;
  logic [7:0]  dbg_offset;
  logic [13:0] vb_wdata, vector_base_reg;
  logic [6:0]  irq_offset;
  logic [mmd_pkg::NPER-1:0] per_sel, sel_seen;
  mmd_pkg::mmd_dreq_t dreq;
  int n_errors = 0, check_count = 0, lat;
  // free running system clock, 50 ns period
  always #25 clk_sys = ~clk_sys;
  mmd_decoder DUT (.clk_sys, .rstn, .fetch_en, .program_addr_bus, .program_fetch_bus,
    .fetch_flash_sel, .flash_addr, .flash_rdata, .dreq, .dreq_pspace, .core_read_bus, .dack,
    .sec_rd, .secondary_data_addr_bus, .secondary_read_bus, .dir_en, .dir_field, .dir_addr,
    .per_sel, .per_addr, .per_wr, .per_wdata, .per_rdata, .dbg_sel, .dbg_offset, .dbg_rdata,
    .jtag_dbg_req, .flash_secure, .jtag_dbg_grant, .vb_wr, .vb_wdata, .irq_pend, .irq_offset,
    .wdog_rst, .vector_base_reg, .vector_address, .vec_in_table);
  mmd_far_model far (.clk_sys, .flash_addr, .flash_rdata, .per_sel, .per_addr, .per_rdata,
    .dbg_sel, .dbg_offset, .dbg_rdata);
  // ****************************************
  // helpers
  // ****************************************
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // counts and verdict, then stop
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // flash image word expected from the model
  function automatic logic [15:0] fl(input logic [14:0] a);
    return {1'b1, a ^ 15'h1234};
  endfunction : fl
  // one primary access held until acked, bounded wait
  task automatic xfer(input logic w, input mmd_pkg::mmd_size_t sz, input logic [23:0] a,
                      input logic [31:0] d, input logic ps);
    @(posedge clk_sys); #1;
    dreq = '{rd: !w, wr: w, size: sz, addr: a, wdata: d};
    dreq_pspace = ps;
    #1 sel_seen = per_sel;
    dsel_seen = dbg_sel;
    wr_seen = {per_wr, per_wdata};
    lat = 0;
    while (lat < 8) begin
      @(posedge clk_sys); #1;
      lat++;
      if (dack === 1'b1) break;
    end
    if (dack !== 1'b1) begin
      check("dack", dack, 1);
      print_verdict();
    end
    rd_val = core_read_bus;
    dreq.rd = 1'b0;
    dreq.wr = 1'b0;
    dreq_pspace = 1'b0;
  endtask : xfer
  // one instruction fetch, data one cycle later
  task automatic fetch(input logic [20:0] a, input logic fs, input logic [15:0] exp);
    @(posedge clk_sys); #1;
    fetch_en = 1'b1;
    program_addr_bus = a;
    #1 check("fetch_flash_sel", fetch_flash_sel, fs);
    @(posedge clk_sys); #1;
    check("program_fetch_bus", program_fetch_bus, exp);
    fetch_en = 1'b0;
  endtask : fetch
  // ****************************************
  // scenarios
  // ****************************************
  // flash fetch at both ends, shared ram window fetch, program data move
  task automatic sc_flash();
    fetch(21'h000000, 1'b1, fl(15'h0000));
    fetch(21'h007FFF, 1'b1, fl(15'h7FFF));
    fetch(21'h008800, 1'b0, 16'h0000);
    xfer(1'b0, mmd_pkg::MMD_SZ_WORD, 24'h000005, 0, 1'b1);
    check("pspace flash read", rd_val[15:0], fl(15'h0005));
    check("pspace latency", lat, 2);
  endtask : sc_flash
  // shared ram through data, alias and program space; reserved ignored
  task automatic sc_ram();
    xfer(1'b1, mmd_pkg::MMD_SZ_WORD, 24'h000010, 32'h0000BEEF, 1'b0);
    xfer(1'b1, mmd_pkg::MMD_SZ_WORD, 24'h001010, 32'h00001111, 1'b0);
    xfer(1'b0, mmd_pkg::MMD_SZ_WORD, 24'h008010, 0, 1'b0);
    check("alias read", rd_val[15:0], 16'hBEEF);
    check("data latency", lat, 1);
    xfer(1'b0, mmd_pkg::MMD_SZ_WORD, 24'h001010, 0, 1'b0);
    check("reserved read", rd_val, 0);
    xfer(1'b0, mmd_pkg::MMD_SZ_WORD, 24'h008010, 0, 1'b1);
    check("pspace ram read", rd_val[15:0], 16'hBEEF);
    fetch(21'h008010, 1'b0, 16'hBEEF);
    xfer(1'b1, mmd_pkg::MMD_SZ_WORD, 24'h008FFF, 32'h00007E57, 1'b1);
    xfer(1'b0, mmd_pkg::MMD_SZ_WORD, 24'h000FFF, 0, 1'b0);
    check("ram top read", rd_val[15:0], 16'h7E57);
  endtask : sc_ram
  // long and byte transfers with a parallel secondary read
  task automatic sc_long();
    xfer(1'b1, mmd_pkg::MMD_SZ_LONG, 24'h000030, 32'h12345678, 1'b0);
    xfer(1'b1, mmd_pkg::MMD_SZ_BYTE, 24'h000032, 32'h000000AB, 1'b0);
    sec_rd = 1'b1;
    secondary_data_addr_bus = 24'h000031;
    xfer(1'b0, mmd_pkg::MMD_SZ_LONG, 24'h000030, 0, 1'b0);
    check("long read", rd_val, 32'h12345678);
    check("secondary read", secondary_read_bus, 16'h1234);
    secondary_data_addr_bus = 24'h00F000;
    xfer(1'b0, mmd_pkg::MMD_SZ_BYTE, 24'h000032, 0, 1'b0);
    check("byte read", rd_val, 32'h000000AB);
    check("secondary non ram", secondary_read_bus, 16'h0000);
    sec_rd = 1'b0;
  endtask : sc_long
  // peripheral selects at bases and range ends, debug window, gaps
  task automatic sc_periph();
    logic [15:0] ad [19] = '{16'hF000, 16'hF03F, 16'hF040, 16'hF080, 16'hF0C0, 16'hF150, 16'hF19F,
      16'hF1E0, 16'hF1F0, 16'hF200, 16'hF230, 16'hF240, 16'hF250, 16'hF260, 16'hF2FF, 16'hF300,
      16'hF400, 16'hF440, 16'hFFFF};
    int ix [19] = '{0, 0, 1, 2, 3, 10, 14, 19, 20, 21, 24, 25, 26, 27, 27, 28, 29, 30, 30};
    for (int i = 0; i < 19; i++) begin
      xfer(1'b0, mmd_pkg::MMD_SZ_WORD, {8'h00, ad[i]}, 0, 1'b0);
      check("per_sel", sel_seen, 31'h1 << ix[i]);
      check("per read", rd_val[15:0], ad[i] ^ 16'h0F0F);
    end
    xfer(1'b0, mmd_pkg::MMD_SZ_WORD, 24'hFFFF10, 0, 1'b0);
    check("dbg_sel", dsel_seen, 1'b1);
    check("dbg read", rd_val[15:0], 16'hDB10);
    xfer(1'b0, mmd_pkg::MMD_SZ_WORD, 24'hFFFEFF, 0, 1'b0);
    check("below dbg", {|sel_seen, dsel_seen, rd_val[15:0]}, 0);
    xfer(1'b0, mmd_pkg::MMD_SZ_WORD, 24'h00EFFF, 0, 1'b0);
    check("below per", {|sel_seen, dsel_seen, rd_val[15:0]}, 0);
    xfer(1'b1, mmd_pkg::MMD_SZ_WORD, 24'h00F23F, 32'h0000C0DE, 1'b0);
    check("per write", {wr_seen, sel_seen[24]}, {17'h1C0DE, 1'b1});
    xfer(1'b1, mmd_pkg::MMD_SZ_WORD, 24'h00F23F, 32'h0000C0DE, 1'b1);
    check("pspace reserved write", {wr_seen[16], |sel_seen}, 0);
  endtask : sc_periph
  // reset vector, watchdog vector, base plus offset, table edge
  task automatic sc_vector();
    check("vb reset", vector_base_reg, 0);
    check("chip vector", vector_address, 0);
    @(posedge clk_sys); #1 wdog_rst = 1'b1;
    @(posedge clk_sys); #1 wdog_rst = 1'b0;
    check("wdog vector", vector_address, 21'h000002);
    check("in table", vec_in_table, 1'b1);
    vb_wr = 1'b1;
    vb_wdata = 14'h0001;
    @(posedge clk_sys); #1 vb_wr = 1'b0;
    irq_pend = 1'b1;
    for (int k = 5; k < 7; k++) begin
      irq_offset = 7'(k);
      repeat (2) @(posedge clk_sys);
      #1 check("irq vector", vector_address, 21'h000080 + 21'(k));
      check("table edge", vec_in_table, k == 5);
    end
    irq_pend = 1'b0;
  endtask : sc_vector
  // direct mode reach and debug port grant
  task automatic sc_misc();
    dir_en = 1'b1;
    dir_field = 6'h3F;
    #1 check("dir_addr", dir_addr, 24'h00003F);
    jtag_dbg_req = 1'b1;
    flash_secure = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 check("grant open", jtag_dbg_grant, 1'b1);
    flash_secure = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 check("grant secure", jtag_dbg_grant, 1'b0);
  endtask : sc_misc
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rstn, fetch_en, dreq_pspace, sec_rd, dir_en, jtag_dbg_req, vb_wr, irq_pend, wdog_rst} = '0;
    {program_addr_bus, secondary_data_addr_bus, dir_field, vb_wdata, irq_offset} = '0;
    flash_secure = 1'b1;
    dreq = '0;
    repeat (12) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    sc_vector();
    sc_flash();
    sc_ram();
    sc_long();
    sc_periph();
    sc_misc();
    print_verdict();
  end
endmodule : tb_memory_map_address_decoder
`default_nettype wire
